// [inc/bfid_map.svh]
// Purpose: Offsets, field positions and reset values of the backlight register bank
// Assumes: Included by bare name from the package and the design
// Notes: Definitions only
`ifndef BFID_MAP_SVH
`define BFID_MAP_SVH

`define BFID_SLAVE_ADDR7 7'h2C
`define BFID_REG_BRIGHT 8'h00
`define BFID_REG_CTL 8'h01
`define BFID_REG_STAT 8'h02
`define BFID_REG_ID 8'h03

`define BFID_BRIGHT_RST 8'hFF
`define BFID_CTL_RST 8'h00
`define BFID_STAT_RST 8'h00
`define BFID_CTL_WMASK 8'h3F

`define BFID_CTL_BLON 0
`define BFID_CTL_PWMSEL 1
`define BFID_CTL_PWMMD 2

`define BFID_ST_FAULT 0
`define BFID_ST_THRM 1
`define BFID_ST_OVV 2
`define BFID_ST_BLSTAT 3
`define BFID_ST_ONE 4
`define BFID_ST_MULTI 5

`define BFID_ID_CLASS 7
`define BFID_CHANNELS 8

`endif

// [inc/bfid_pkg.sv]
// Purpose: Types for the backlight register bank
// Assumes: bfid_map.svh on the include path
// Notes: Constants live in the map header
`include "bfid_map.svh"

package bfid_pkg;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } bfid_state_t;

  typedef enum logic [2:0]
  {
    PH_ADDR = 3'h1,
    PH_CMD = 3'h2,
    PH_DATA = 3'h4
  } bfid_phase_t;

  typedef struct packed
  {
    logic thermal;
    logic overvoltage;
    logic [`BFID_CHANNELS-1:0] channel;
  } bfid_fault_in_t;

endpackage

// [design/bfid_regs.sv]
// Purpose: Byte-protocol serial slave with brightness, control, fault/status and ID registers
// Assumes: Fault inputs come from logic on i_clock; bus pins are asynchronous
// Notes: Bus clock must be well below i_clock/8
// How it works
// RL1: A set fault summary stays set after its cause goes away.
// RL2: The summary clears when the backlight-on request bit toggles or when zero is written to it.
// RL3: After a clear the summary sets again while any fault is still present.
// RL4: The backlight lit status never sets the fault summary.
// RL5: Faults are not recorded while the main input supply is absent.
// RL6: The fault/status register reads all zero after reset.
// RL7: The ID register packs a class bit, a 4-bit vendor and a 3-bit revision.
// RL8: The ID register is read-only and its top bit always reads one.
// RL9: The revision field starts at zero and steps by one per released revision.
// RL10: Brightness is an 8-bit read/write field selecting one of 256 levels; writes are ignored here while the PWM select bit is set.
// RL11: The ID fields have fixed widths naming driver class, vendor and revision.
// RL12: The fault summary is the OR of thermal, overvoltage, multi- and one-channel faults.
// RL13: The status read shows backlight lit as one while lit and zero while off.
// RL14: Only the fault summary bit of the status register is writable, and only to clear.
// RL15: The multi-channel bit means two or more faulted channels, the one-channel bit one or more.
// RL16: Writes to the ID register are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "bfid_map.svh"

module bfid_regs
  import bfid_pkg::*;
#(
  parameter logic [3:0] VENDOR_ID = 4'h3,   // Arbitrary value
  parameter logic [2:0] SILICON_REV = 3'h0  // First release; step by one per release
)
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire bfid_fault_in_t i_faults,
  input wire logic i_backlight_lit_status,
  input wire logic i_main_input_supply_ok,
  output logic [7:0] o_brightness_level_field,
  output logic o_backlight_on_request,
  output logic o_pwm_select,
  output logic o_pwm_mode,
  output logic o_fault_summary
);

  function automatic logic two_or_more(input logic [`BFID_CHANNELS-1:0] v);
    two_or_more = (v & (v - 1'b1)) != '0;
  endfunction

  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic scl_d1_q;
  logic sda_d1_q;
  bfid_state_t state_q;
  bfid_phase_t phase_q;
  logic [2:0] cnt_q;
  logic [7:0] shift_q;
  logic rw_q;
  logic ack_pend_q;
  logic [7:0] regsel_q;
  logic sda_oe_q;
  logic sda_out_q;
  logic [7:0] bright_q;
  logic [7:0] ctl_q;
  logic fault_q;
  logic [5:1] stat_live_q;

  // Only the second synchroniser stage feeds logic
  wire logic scl = scl_s_q[1];
  wire logic sda = sda_s_q[1];
  wire logic scl_rise = scl & ~scl_d1_q;
  wire logic scl_fall = ~scl & scl_d1_q;
  wire logic bus_start = scl & scl_d1_q & sda_d1_q & ~sda;
  wire logic bus_stop = scl & scl_d1_q & ~sda_d1_q & sda;

  wire logic [7:0] byte_val = {shift_q[6:0], sda};
  wire logic byte_done = (state_q == ST_RX) & scl_rise & (cnt_q == 3'h7);
  wire logic addr_match = byte_val[7:1] == `BFID_SLAVE_ADDR7;

  wire logic wr_stb = byte_done & (phase_q == PH_DATA);
  wire logic wr_bright = wr_stb & (regsel_q == `BFID_REG_BRIGHT) & ~ctl_q[`BFID_CTL_PWMSEL];
  wire logic wr_ctl = wr_stb & (regsel_q == `BFID_REG_CTL);
  wire logic wr_stat = wr_stb & (regsel_q == `BFID_REG_STAT);
  wire logic bl_toggle = wr_ctl & (byte_val[`BFID_CTL_BLON] != ctl_q[`BFID_CTL_BLON]);
  wire logic fault_clr = bl_toggle | (wr_stat & ~byte_val[`BFID_ST_FAULT]); // RL2 RL14

  // Supply loss masks every fault source
  wire logic flt_thrm = i_faults.thermal & i_main_input_supply_ok; // RL5
  wire logic flt_ovv = i_faults.overvoltage & i_main_input_supply_ok; // RL5
  wire logic flt_one = (|i_faults.channel) & i_main_input_supply_ok; // RL15
  wire logic flt_multi = two_or_more(i_faults.channel) & i_main_input_supply_ok; // RL15
  wire logic any_fault = flt_thrm | flt_ovv | flt_one | flt_multi; // RL12 RL4

  // Set beats clear, so a persisting fault re-latches at once
  wire logic fault_d = any_fault ? 1'b1 : (fault_clr ? 1'b0 : fault_q); // RL1 RL2 RL3
  wire logic [5:1] stat_live_d = {flt_multi, flt_one, i_backlight_lit_status, flt_ovv, flt_thrm};

  // No write strobe exists for the ID index, so host writes fall away
  wire logic [7:0] id_word = {1'b1, VENDOR_ID, SILICON_REV}; // RL7 RL8 RL9 RL11 RL16
  wire logic [7:0] stat_word = {2'h0, stat_live_q, fault_q}; // RL13
  wire logic [7:0] rd_data =
    (regsel_q == `BFID_REG_BRIGHT) ? bright_q :
    (regsel_q == `BFID_REG_CTL) ? ctl_q :
    (regsel_q == `BFID_REG_STAT) ? stat_word :
    (regsel_q == `BFID_REG_ID) ? id_word : 8'h00;

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end
    else
    begin
      scl_s_q <= {scl_s_q[0], i_scl};
      sda_s_q <= {sda_s_q[0], i_sda};
      scl_d1_q <= scl;
      sda_d1_q <= sda;
    end
  end

  // Bus sequencer: sample on rising clock, drive on falling clock
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q <= ST_IDLE;
      phase_q <= PH_ADDR;
      cnt_q <= 3'h0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      ack_pend_q <= 1'b0;
      regsel_q <= 8'h00;
      sda_oe_q <= 1'b0;
      sda_out_q <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
      ack_pend_q <= 1'b0;
    end
    else if (bus_start)
    begin
      state_q <= ST_RX;
      phase_q <= PH_ADDR;
      cnt_q <= 3'h0;
      sda_oe_q <= 1'b0;
      ack_pend_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_RX:
        begin
          if (scl_rise)
          begin
            shift_q <= byte_val;
            cnt_q <= cnt_q + 3'h1;
            if (byte_done)
            begin
              if (phase_q == PH_ADDR)
              begin
                rw_q <= byte_val[0];
                ack_pend_q <= addr_match;
                if (!addr_match)
                begin
                  state_q <= ST_IDLE;
                end
              end
              else
              begin
                ack_pend_q <= 1'b1;
                if (phase_q == PH_CMD)
                begin
                  regsel_q <= byte_val;
                end
              end
            end
          end
          else if (scl_fall && ack_pend_q)
          begin
            state_q <= ST_ACK;
            sda_oe_q <= 1'b1;
            ack_pend_q <= 1'b0;
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            cnt_q <= 3'h0;
            if (phase_q == PH_ADDR && rw_q)
            begin
              state_q <= ST_TX;
              shift_q <= rd_data;
              sda_oe_q <= ~rd_data[7];
            end
            else
            begin
              state_q <= ST_RX;
              sda_oe_q <= 1'b0;
              phase_q <= (phase_q == PH_ADDR) ? PH_CMD : PH_DATA;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_q == 3'h7)
            begin
              state_q <= ST_MACK;
              sda_oe_q <= 1'b0;
            end
            else
            begin
              shift_q <= {shift_q[6:0], 1'b0};
              sda_oe_q <= ~shift_q[6];
              cnt_q <= cnt_q + 3'h1;
            end
          end
        end
        ST_MACK:
        begin
          // Master ack reloads the same register; nack ends the read
          if (scl_rise)
          begin
            state_q <= sda ? ST_IDLE : ST_ACK;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      bright_q <= `BFID_BRIGHT_RST;
      ctl_q <= `BFID_CTL_RST;
      fault_q <= 1'b0; // RL6
      stat_live_q <= 5'h00; // RL6
    end
    else
    begin
      if (wr_bright)
      begin
        bright_q <= byte_val; // RL10
      end
      if (wr_ctl)
      begin
        ctl_q <= byte_val & `BFID_CTL_WMASK;
      end
      fault_q <= fault_d;
      stat_live_q <= stat_live_d; // RL13 RL14
    end
  end

  assign o_sda_out = sda_out_q;
  assign o_sda_oe = sda_oe_q;
  assign o_brightness_level_field = bright_q;
  assign o_backlight_on_request = ctl_q[`BFID_CTL_BLON];
  assign o_pwm_select = ctl_q[`BFID_CTL_PWMSEL];
  assign o_pwm_mode = ctl_q[`BFID_CTL_PWMMD];
  assign o_fault_summary = fault_q;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  fault_hold_a: assert property (fault_q && !fault_clr |=> fault_q) // RL1
    else $error("fault summary dropped without a clear");
  fault_clear_a: assert property (fault_clr && !any_fault |=> !fault_q) // RL2
    else $error("fault summary not cleared");
  fault_relatch_a: assert property (fault_clr && any_fault |=> fault_q[*2]) // RL3
    else $error("fault summary lost while fault present");
  lit_no_fault_a: assert property (!fault_q && (i_faults == '0) |=> !fault_q) // RL4
    else $error("fault summary set without a fault");
  supply_mask_a: assert property (!i_main_input_supply_ok && !fault_q |=> !fault_q) // RL5
    else $error("fault recorded during supply loss");
  stat_reset_a: assert property ($rose(i_rst_b) |-> stat_word == 8'h00) // RL6
    else $error("status not zero after reset");
  id_read_a: assert property ($rose(state_q == ST_TX) && regsel_q == `BFID_REG_ID
    |-> shift_q[7] && shift_q == {1'b1, VENDOR_ID, SILICON_REV}) // RL8
    else $error("ID read value wrong");
  id_no_write_a: assert property (wr_stb && regsel_q == `BFID_REG_ID
    |=> $stable(bright_q) && $stable(ctl_q)) // RL16
    else $error("ID write disturbed registers");
  bright_write_a: assert property (wr_bright |=> bright_q == $past(byte_val)) // RL10
    else $error("brightness write lost");
  lit_status_a: assert property (1'b1 |=> stat_word[3] == $past(i_backlight_lit_status)) // RL13
    else $error("lit status not reported");
  chan_count_a: assert property (i_main_input_supply_ok && $onehot(i_faults.channel)
    |=> stat_live_q[`BFID_ST_ONE] && !stat_live_q[`BFID_ST_MULTI]) // RL15
    else $error("channel fault count wrong");

  write_seen_c: cover property (wr_ctl);
  read_seen_c: cover property ($rose(state_q == ST_TX) && regsel_q == `BFID_REG_STAT);
  fault_cycle_c: cover property (fault_q ##[1:1000] fault_clr ##1 !fault_q);
  relatch_c: cover property (fault_clr && any_fault);

endmodule

`default_nettype wire

// [dv/bfid_host.sv]
// Purpose: Host master model driving byte write and byte read cycles
// Assumes: Open-drain data line with pull-up, wired level fed back on i_sda
// Notes: Phases of at least 10 clocks keep the slave's synchroniser comfortable
`timescale 1ns/1ps
`default_nettype none

module bfid_host (
  input wire logic i_clock,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask

  // Data moves a few clocks after the fall, never beside an SCL edge
  task automatic bit_x(input logic b, output logic r);
    hold(3);
    o_sda_low = ~b;
    hold(8);
    o_scl = 1'b1;
    hold(5);
    r = i_sda;
    hold(5);
    o_scl = 1'b0;
  endtask

  task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx, output logic ack_n);
    for (int k = 7; k >= 0; k--)
      bit_x(tx[k], rx[k]);
    bit_x(1'b1, ack_n);
  endtask

  task automatic start();
    hold(3);
    o_sda_low = 1'b0;
    hold(8);
    o_scl = 1'b1;
    hold(10);
    o_sda_low = 1'b1;
    hold(10);
    o_scl = 1'b0;
  endtask

  task automatic stop();
    hold(3);
    o_sda_low = 1'b1;
    hold(8);
    o_scl = 1'b1;
    hold(10);
    o_sda_low = 1'b0;
    hold(10);
  endtask

  task automatic write_byte(input logic [7:0] idx, input logic [7:0] val, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    byte_x(8'h58, rx, a0);
    byte_x(idx, rx, a1);
    byte_x(val, rx, a2);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask

  // Last byte gets a NACK so the slave lets go of the line
  task automatic read_byte(input logic [7:0] idx, output logic [7:0] val, output logic ok);
    logic a0, a1, a2, nack;
    start();
    byte_x(8'h58, val, a0);
    byte_x(idx, val, a1);
    start();
    byte_x(8'h59, val, a2);
    byte_x(8'hFF, val, nack);
    stop();
    ok = ~(a0 | a1 | a2) & nack;
  endtask
endmodule

`default_nettype wire

// [dv/test_backlight_fault_id_regs.sv]
// Purpose: Self-checking bench for the backlight register bank
// Assumes: bfid_host model on the bus pins
// Notes: ID built from VENDOR_ID 4'h5 (arbitrary) and revision 0
`timescale 1ns/1ps
`default_nettype none

module test_backlight_fault_id_regs;
  import bfid_pkg::*;
  logic i_clock;
  logic i_rst_b;
  bfid_fault_in_t faults;
  logic lit;
  logic supply_ok;
  logic scl, sda_low, sda_out, sda_oe, summary, on_req, ok, sda_w, pwm_sel, pwm_md;
  logic [7:0] bright, rd_v;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  bfid_fault_in_t fsrc [4] = '{10'h200, 10'h100, 10'h004, 10'h081};
  logic [7:0] fexp [4] = '{8'h03, 8'h05, 8'h11, 8'h31};

  assign sda_w = ~(sda_low | sda_oe);

  bfid_regs #(.VENDOR_ID(4'h5)) bfid_regs_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda_w),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_faults(faults),
    .i_backlight_lit_status(lit), .i_main_input_supply_ok(supply_ok),
    .o_brightness_level_field(bright), .o_backlight_on_request(on_req),
    .o_pwm_select(pwm_sel), .o_pwm_mode(pwm_md), .o_fault_summary(summary));

  bfid_host bfid_host_i (.i_clock(i_clock), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));

  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge i_clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      miscompares++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bfid_host_i.read_byte(idx, rd_v, ok);
    chk({7'h00, ok}, 8'h01);
    chk(rd_v, exp);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    bfid_host_i.write_byte(idx, val, ok);
    chk({7'h00, ok}, 8'h01);
  endtask

  initial
  begin
    i_rst_b = 1'b0;
    faults = '0;
    lit = 1'b0;
    supply_ok = 1'b1;
    bfid_host_i.hold(4);
    i_rst_b = 1'b1;
    bfid_host_i.hold(6);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'hA8);
    wr(8'h03, 8'h00);
    rd(8'h03, 8'hA8);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h5A);
    rd(8'h00, 8'h5A);
    chk(bright, 8'h5A);
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h3F);
    chk({6'h00, pwm_sel, pwm_md}, 8'h03);
    // PWM input owns brightness now, so the write must not land
    wr(8'h00, 8'h11);
    rd(8'h00, 8'h5A);
    wr(8'h01, 8'h00);
    chk({6'h00, pwm_sel, pwm_md}, 8'h00);
    $display("test identity and brightness done");
    for (int k = 0; k < 4; k++)
    begin
      faults = fsrc[k];
      bfid_host_i.hold(3);
      rd(8'h02, fexp[k]);
      faults = '0;
      bfid_host_i.hold(3);
      chk({7'h00, summary}, 8'h01);
      rd(8'h02, 8'h01);
      wr(8'h02, 8'hFE);
      rd(8'h02, 8'h00);
    end
    $display("test fault sources done");
    faults = 10'h200;
    bfid_host_i.hold(3);
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h03);
    faults = '0;
    bfid_host_i.hold(3);
    wr(8'h01, 8'h01);
    chk({7'h00, summary}, 8'h00);
    chk({7'h00, on_req}, 8'h01);
    $display("test re-set and toggle clear done");
    lit = 1'b1;
    bfid_host_i.hold(3);
    rd(8'h02, 8'h08);
    chk({7'h00, summary}, 8'h00);
    lit = 1'b0;
    supply_ok = 1'b0;
    faults = 10'h3FF;
    bfid_host_i.hold(3);
    rd(8'h02, 8'h00);
    chk({7'h00, summary}, 8'h00);
    $display("test lit status and supply loss done");
    supply_ok = 1'b1;
    faults = 10'h100;
    bfid_host_i.hold(3);
    faults = '0;
    bfid_host_i.hold(3);
    chk({7'h00, summary}, 8'h01);
    i_rst_b = 1'b0;
    bfid_host_i.hold(4);
    chk({7'h00, summary}, 8'h00);
    i_rst_b = 1'b1;
    bfid_host_i.hold(6);
    rd(8'h02, 8'h00);
    rd(8'h00, 8'hFF);
    chk({7'h00, sda_out}, 8'h00);
    $display("test mid-run reset done");
    summarize();
  end
endmodule

`default_nettype wire
